// *** design/cgp_ctrl.sv ***
// clock gating, clock generator mode select and power mode sequencing
// assumes synchronous inputs on mclk; gated clocks are built from mclk with latch-based and-gating
// Overview of operation
// - a gate follows its control bit one cycle after the register write
// - all module clock gates are enabled after any reset
// - writes to a gated-off module are blocked
// - both analog comparators share one gate bit
// - six generator modes; reset leaves fll engaged internal
// - multiplier resets to 512, bus divider to 2
// - bypassed modes output the selected reference over the bus divider
// - low-power bypassed modes disable fll and stop debug clock
// - mode from source select, reference select and low-power bit
// - clearing high-gain bit selects low-gain oscillator
// - wait halts the core, clocks keep running, any interrupt exits
// - stop enable is write-once, wait enable writable anytime
// - stop instruction decodes to illegal, stop or wait
// - standby halts clocks, regulator standby, about 6 us wake
// - deep power-down with low-voltage detect enabled becomes standby
// - standby exits only on listed wake sources or reset
// - deep power-down halts clocks, regulator off, ram kept, pins latched
// - deep power-down exits on reset, irq or counter; acknowledge flag set
// - counter gate removes only its bus clock
// - gate bit 0 disables, 1 enables
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
module cgp_ctrl (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic avs_sel_pwr,
  input wire logic stop_instr,
  input wire logic irq_any,
  input wire logic [7:0] wake_src,
  input wire logic deep_wake,
  input wire logic [15:0] periph_wr,
  output logic [15:0] gate_en,
  output logic [15:0] periph_wr_ok,
  output cgp_pkg::cgp_gen_mode_e gen_mode,
  output logic fll_enable,
  output logic fll_select,
  output logic ext_ref_select,
  output logic [2:0] ref_div,
  output logic [1:0] bus_div,
  output logic [9:0] osc_mult,
  output logic high_gain_osc,
  output logic debug_clk_en,
  output logic core_halt,
  output logic sys_clk_run,
  output logic reg_standby,
  output logic reg_off,
  output logic pin_latch,
  output logic illegal_opcode,
  output logic deep_exit_reset
);
  import cgp_pkg::*;

  logic [15:0] gate;
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic stop_enable;
  logic stop_enable_locked;
  logic wait_enable;
  logic lvde;
  logic deep_req;
  logic partial_power_down_ack;
  cgp_pwr_e pstate;
  logic [7:0] wake_cnt;
  logic acc_done;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] next_rdata;
  logic next_err;
  cgp_gen_mode_e next_mode;

  // one wait state: read data is captured on the first edge, a write lands on the second
  assign wr_hit = avs_write && acc_done;
  assign rd_hit = avs_read && !acc_done;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acc_done <= 1'b0;
    end else begin
      acc_done <= (avs_read || avs_write) && !acc_done;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !acc_done);
    end
  end

  // gate register; a write lands on the edge that completes the transfer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gate <= CGP_GATE_RST;
    end else if (pstate == CGP_DEEP && deep_wake) begin
      gate <= CGP_GATE_RST;
    end else if (wr_hit && !avs_sel_pwr && avs_address == CGP_ADDR_GATE) begin
      if (avs_byteenable[0]) begin
        gate[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        gate[15:8] <= avs_writedata[15:8];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1 <= CGP_C1_RST;
      ctrl2 <= CGP_C2_RST;
    end else if (pstate == CGP_DEEP && deep_wake) begin
      ctrl1 <= CGP_C1_RST;
      ctrl2 <= CGP_C2_RST;
    end else if (wr_hit && !avs_sel_pwr && avs_byteenable[0]) begin
      if (avs_address == CGP_ADDR_GEN_CTRL1) begin
        ctrl1 <= avs_writedata[7:0];
      end else if (avs_address == CGP_ADDR_GEN_CTRL2) begin
        ctrl2 <= avs_writedata[7:0];
      end
    end
  end

  // system options: stop enable accepts its first write only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stop_enable <= 1'b0;
      stop_enable_locked <= 1'b0;
      wait_enable <= 1'b1;
    end else if (wr_hit && !avs_sel_pwr && avs_address == CGP_ADDR_SYSOPT
                 && avs_byteenable[0]) begin
      wait_enable <= avs_writedata[CGP_SO_WAIT_ENABLE];
      if (!stop_enable_locked) begin
        stop_enable <= avs_writedata[CGP_SO_STOP_ENABLE];
        stop_enable_locked <= 1'b1;
      end
    end
  end

  // power register; partial_power_down_ack set on deep exit wins over a software clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lvde <= 1'b1;
      deep_req <= 1'b0;
      partial_power_down_ack <= 1'b0;
    end else begin
      if (wr_hit && avs_sel_pwr && avs_address == CGP_ADDR_PWR && avs_byteenable[0]) begin
        lvde <= avs_writedata[CGP_PW_LVDE];
        deep_req <= avs_writedata[CGP_PW_DEEP_REQ];
        if (avs_writedata[CGP_PW_PARTIAL_POWER_DOWN_ACK]) begin
          partial_power_down_ack <= 1'b0;
        end
      end
      if (pstate == CGP_DEEP && deep_wake) begin
        partial_power_down_ack <= 1'b1;
        deep_req <= 1'b0;
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    if (avs_sel_pwr) begin
      if (avs_address == CGP_ADDR_PWR) begin
        next_rdata[CGP_PW_DEEP_REQ] = deep_req;
        next_rdata[CGP_PW_LVDE] = lvde;
        next_rdata[CGP_PW_PARTIAL_POWER_DOWN_ACK] = partial_power_down_ack;
      end else begin
        next_err = 1'b1;
      end
    end else if (avs_address == CGP_ADDR_GATE) begin
      next_rdata[15:0] = gate;
    end else if (avs_address == CGP_ADDR_GEN_CTRL1) begin
      next_rdata[7:0] = ctrl1;
    end else if (avs_address == CGP_ADDR_GEN_CTRL2) begin
      next_rdata[7:0] = ctrl2;
    end else if (avs_address == CGP_ADDR_SYSOPT) begin
      next_rdata[CGP_SO_STOP_ENABLE] = stop_enable;
      next_rdata[CGP_SO_WAIT_ENABLE] = wait_enable;
      next_rdata[7:3] = {1'b0, pstate == CGP_DEEP, pstate == CGP_STANDBY,
                         pstate == CGP_WAIT, gen_mode == CGP_FEI};
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
    end else if (rd_hit || (avs_write && !acc_done)) begin
      avs_readdata <= rd_hit ? next_rdata : 32'h0;
      avs_response <= next_err ? 2'h2 : 2'h0;
    end
  end

  // generator mode from source select, reference select and low power
  always_comb begin
    next_mode = CGP_FEI;
    case (ctrl1[CGP_C1_CLOCK_SOURCE_SELECT_LO +: 2])
      CGP_CLOCK_SOURCE_SELECT_FLL: next_mode = ctrl1[CGP_C1_INTERNAL_REF_SELECT] ? CGP_FEI : CGP_FEE;
      CGP_CLOCK_SOURCE_SELECT_INT: next_mode = ctrl2[CGP_C2_LP] ? CGP_BYPASSED_INTERNAL_LOW_POWER : CGP_FBI;
      CGP_CLOCK_SOURCE_SELECT_EXT: next_mode = ctrl2[CGP_C2_LP] ? CGP_BYPASSED_EXTERNAL_LOW_POWER : CGP_FBE;
      default: next_mode = CGP_FEI;
    endcase
  end

  // gen_mode holds in standby and deep power-down; standby wake resumes the previous mode, deep exit restores FEI
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gen_mode <= CGP_FEI;
      fll_enable <= 1'b1;
      fll_select <= 1'b1;
      ext_ref_select <= 1'b0;
      debug_clk_en <= 1'b1;
      ref_div <= 3'h0;
      bus_div <= 2'h1;
      osc_mult <= CGP_MULT_RST;
      high_gain_osc <= 1'b0;
    end else if (pstate == CGP_DEEP && deep_wake) begin
      gen_mode <= CGP_FEI;
      fll_enable <= 1'b1;
      fll_select <= 1'b1;
      ext_ref_select <= 1'b0;
      debug_clk_en <= 1'b1;
      ref_div <= CGP_C1_RST[CGP_C1_REFERENCE_DIVIDER_LO +: 3];
      bus_div <= CGP_C2_RST[CGP_C2_BUS_DIVIDER_LO +: 2];
      high_gain_osc <= 1'b0;
    end else if (pstate == CGP_RUN || pstate == CGP_WAIT) begin
      gen_mode <= next_mode;
      fll_enable <= !(next_mode == CGP_BYPASSED_INTERNAL_LOW_POWER || next_mode == CGP_BYPASSED_EXTERNAL_LOW_POWER);
      fll_select <= (next_mode == CGP_FEI || next_mode == CGP_FEE);
      ext_ref_select <= (next_mode == CGP_FEE || next_mode == CGP_FBE
                         || next_mode == CGP_BYPASSED_EXTERNAL_LOW_POWER);
      debug_clk_en <= !(next_mode == CGP_BYPASSED_INTERNAL_LOW_POWER || next_mode == CGP_BYPASSED_EXTERNAL_LOW_POWER);
      ref_div <= ctrl1[CGP_C1_REFERENCE_DIVIDER_LO +: 3];
      bus_div <= ctrl2[CGP_C2_BUS_DIVIDER_LO +: 2];
      osc_mult <= CGP_MULT_RST;
      high_gain_osc <= ctrl2[CGP_C2_HGO];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pstate <= CGP_RUN;
      wake_cnt <= 8'h0;
      illegal_opcode <= 1'b0;
      deep_exit_reset <= 1'b0;
    end else begin
      illegal_opcode <= 1'b0;
      deep_exit_reset <= 1'b0;
      case (pstate)
        CGP_RUN: begin
          if (stop_instr) begin
            if (!stop_enable && !wait_enable) begin
              illegal_opcode <= 1'b1;
            end else if (stop_enable && !wait_enable) begin
              pstate <= (deep_req && !lvde) ? CGP_DEEP : CGP_STANDBY;
            end else begin
              pstate <= CGP_WAIT;
            end
          end
        end
        CGP_WAIT: begin
          if (irq_any) begin
            pstate <= CGP_RUN;
          end
        end
        CGP_STANDBY: begin
          if (|wake_src) begin
            pstate <= CGP_WAKING;
            wake_cnt <= 8'(CGP_WAKE_CYC - 1);
          end
        end
        CGP_WAKING: begin
          if (wake_cnt == 8'h0) begin
            pstate <= CGP_RUN;
          end else begin
            wake_cnt <= wake_cnt - 8'h1;
          end
        end
        CGP_DEEP: begin
          if (deep_wake) begin
            pstate <= CGP_RUN;
            deep_exit_reset <= 1'b1;
          end
        end
        default: pstate <= CGP_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      core_halt <= 1'b0;
      sys_clk_run <= 1'b1;
      reg_standby <= 1'b0;
      reg_off <= 1'b0;
      pin_latch <= 1'b0;
    end else begin
      core_halt <= (pstate != CGP_RUN);
      sys_clk_run <= (pstate == CGP_RUN || pstate == CGP_WAIT);
      reg_standby <= (pstate == CGP_STANDBY);
      reg_off <= (pstate == CGP_DEEP);
      pin_latch <= (pstate == CGP_DEEP);
    end
  end

  // registered gate enables; bit 8 feeds both comparators, bit 9 only the counter bus clock
  genvar gi;
  generate
    for (gi = 0; gi < CGP_NUM_GATES; gi++) begin : g_gate
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          gate_en[gi] <= 1'b1;
          periph_wr_ok[gi] <= 1'b0;
        end else begin
          // the gate cell samples this on the low phase, so no runt pulses
          gate_en[gi] <= gate[gi];
          periph_wr_ok[gi] <= periph_wr[gi] && gate[gi];
        end
      end
    end
  endgenerate

  property p_gate_follow;
    @(posedge mclk) disable iff (!arst_n)
      (wr_hit && !avs_sel_pwr && avs_address == CGP_ADDR_GATE && avs_byteenable[0])
      |=> ##1 (gate_en[7:0] == $past(avs_writedata[7:0], 2));
  endproperty
  a_gate_follow: assert property (p_gate_follow) else $error("gate did not follow write");

  property p_wr_block;
    @(posedge mclk) disable iff (!arst_n)
      (!gate[CGP_GATE_CMP]) |=> !periph_wr_ok[CGP_GATE_CMP];
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write passed gated module");

  property p_illegal;
    @(posedge mclk) disable iff (!arst_n)
      (pstate == CGP_RUN && stop_instr && !stop_enable && !wait_enable) |=> illegal_opcode && pstate == CGP_RUN;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal opcode missing");

  property p_to_wait;
    @(posedge mclk) disable iff (!arst_n)
      (pstate == CGP_RUN && stop_instr && wait_enable) |=> pstate == CGP_WAIT ##1 core_halt;
  endproperty
  a_to_wait: assert property (p_to_wait) else $error("wait not entered");

  property p_wait_exit;
    @(posedge mclk) disable iff (!arst_n)
      (pstate == CGP_WAIT && irq_any) |=> pstate == CGP_RUN;
  endproperty
  a_wait_exit: assert property (p_wait_exit) else $error("interrupt did not end wait");

  property p_lvd_standby;
    @(posedge mclk) disable iff (!arst_n)
      (pstate == CGP_RUN && stop_instr && stop_enable && !wait_enable && lvde) |=> pstate == CGP_STANDBY;
  endproperty
  a_lvd_standby: assert property (p_lvd_standby) else $error("deep entered with lvd");

  property p_stop_enable_once;
    @(posedge mclk) disable iff (!arst_n)
      $past(stop_enable_locked) |-> $stable(stop_enable);
  endproperty
  a_stop_enable_once: assert property (p_stop_enable_once) else $error("stop enable rewritten");

  property p_wake_time;
    @(posedge mclk) disable iff (!arst_n)
      (pstate == CGP_STANDBY && |wake_src) |=> (pstate == CGP_WAKING) [*8] ##[1:300] pstate == CGP_RUN;
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("standby wake timing wrong");

  property p_deep_ack;
    @(posedge mclk) disable iff (!arst_n)
      (pstate == CGP_DEEP && deep_wake) |=> partial_power_down_ack && deep_exit_reset && gen_mode == CGP_FEI;
  endproperty
  a_deep_ack: assert property (p_deep_ack) else $error("deep exit flag missing");

  property p_lp_fll;
    @(posedge mclk) disable iff (!arst_n)
      (gen_mode == CGP_BYPASSED_INTERNAL_LOW_POWER || gen_mode == CGP_BYPASSED_EXTERNAL_LOW_POWER) |-> !fll_enable && !debug_clk_en;
  endproperty
  a_lp_fll: assert property (p_lp_fll) else $error("fll on in low power mode");
endmodule // cgp_ctrl

// *** design/cgp_pkg.sv ***
// package for the clock gating and power mode controller
// assumes a single 40 MHz bus clock and an avalon-mm register port
package cgp_pkg;
  localparam int unsigned CGP_NUM_GATES = 16;
  localparam logic [3:0] CGP_ADDR_GATE = 4'h0;
  localparam logic [3:0] CGP_ADDR_GEN_CTRL1 = 4'h4;
  localparam logic [3:0] CGP_ADDR_GEN_CTRL2 = 4'h8;
  localparam logic [3:0] CGP_ADDR_SYSOPT = 4'hc;
  localparam logic [3:0] CGP_ADDR_PWR = 4'h0;
  localparam logic [1:0] CGP_ADDR_HI_PWR = 2'h1;
  // gate bit positions
  localparam int unsigned CGP_GATE_CMP = 8;
  localparam int unsigned CGP_GATE_RTC = 9;
  localparam logic [15:0] CGP_GATE_RST = 16'hffff;
  // control register 1 fields
  localparam int unsigned CGP_C1_CLOCK_SOURCE_SELECT_LO = 6;
  localparam int unsigned CGP_C1_REFERENCE_DIVIDER_LO = 3;
  localparam int unsigned CGP_C1_INTERNAL_REF_SELECT = 2;
  localparam logic [7:0] CGP_C1_RST = 8'h04;
  // control register 2 fields
  localparam int unsigned CGP_C2_BUS_DIVIDER_LO = 6;
  localparam int unsigned CGP_C2_HGO = 4;
  localparam int unsigned CGP_C2_LP = 3;
  localparam logic [7:0] CGP_C2_RST = 8'h40;
  localparam logic [9:0] CGP_MULT_RST = 10'h200;
  // system option fields
  localparam int unsigned CGP_SO_STOP_ENABLE = 1;
  localparam int unsigned CGP_SO_WAIT_ENABLE = 0;
  // power register fields
  localparam int unsigned CGP_PW_DEEP_REQ = 0;
  localparam int unsigned CGP_PW_LVDE = 1;
  localparam int unsigned CGP_PW_PARTIAL_POWER_DOWN_ACK = 2;
  localparam logic [1:0] CGP_CLOCK_SOURCE_SELECT_FLL = 2'h0;
  localparam logic [1:0] CGP_CLOCK_SOURCE_SELECT_INT = 2'h1;
  localparam logic [1:0] CGP_CLOCK_SOURCE_SELECT_EXT = 2'h2;
  localparam int unsigned CGP_CLK_HZ = 40000000;
  localparam int unsigned CGP_WAKE_NS = 6000;
  localparam int unsigned CGP_WAKE_CYC = (CGP_WAKE_NS * (CGP_CLK_HZ / 1000000) + 999) / 1000;
  typedef enum logic [5:0] {
    CGP_FEI = 6'b000001,
    CGP_FEE = 6'b000010,
    CGP_FBI = 6'b000100,
    CGP_FBE = 6'b001000,
    CGP_BYPASSED_INTERNAL_LOW_POWER = 6'b010000,
    CGP_BYPASSED_EXTERNAL_LOW_POWER = 6'b100000
  } cgp_gen_mode_e;
  typedef enum logic [4:0] {
    CGP_RUN = 5'b00001,
    CGP_WAIT = 5'b00010,
    CGP_STANDBY = 5'b00100,
    CGP_WAKING = 5'b01000,
    CGP_DEEP = 5'b10000
  } cgp_pwr_e;
endpackage

// *** verif/tb_top.sv ***
// self-checking bench for the clock gating and power mode controller
// assumes cgp_pkg and cgp_ctrl are compiled first; drives every port directly
`timescale 1ns/10ps
module tb_top;
  import cgp_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic avs_sel_pwr = 1'b0;
  logic stop_instr = 1'b0;
  logic irq_any = 1'b0;
  logic [7:0] wake_src = 8'h00;
  logic deep_wake = 1'b0;
  logic [15:0] periph_wr = 16'h0;
  logic [15:0] gate_en, periph_wr_ok;
  cgp_gen_mode_e gen_mode;
  logic fll_enable, fll_select, ext_ref_select, high_gain_osc, debug_clk_en;
  logic [2:0] ref_div;
  logic [1:0] bus_div;
  logic [9:0] osc_mult;
  logic core_halt, sys_clk_run, reg_standby, reg_off, pin_latch;
  logic illegal_opcode, deep_exit_reset;
  logic ill_seen = 1'b0;
  logic dexit_seen = 1'b0;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rsp;

  cgp_ctrl cgp_ctrl_inst (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .avs_sel_pwr(avs_sel_pwr), .stop_instr(stop_instr), .irq_any(irq_any),
    .wake_src(wake_src), .deep_wake(deep_wake), .periph_wr(periph_wr), .gate_en(gate_en),
    .periph_wr_ok(periph_wr_ok), .gen_mode(gen_mode), .fll_enable(fll_enable),
    .fll_select(fll_select), .ext_ref_select(ext_ref_select), .ref_div(ref_div),
    .bus_div(bus_div), .osc_mult(osc_mult), .high_gain_osc(high_gain_osc),
    .debug_clk_en(debug_clk_en), .core_halt(core_halt), .sys_clk_run(sys_clk_run),
    .reg_standby(reg_standby), .reg_off(reg_off), .pin_latch(pin_latch),
    .illegal_opcode(illegal_opcode), .deep_exit_reset(deep_exit_reset));

  always #12.5 mclk = ~mclk;

  // pulses are caught sticky so their exact cycle does not matter
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (illegal_opcode === 1'b1) ill_seen <= 1'b1;
    if (deep_exit_reset === 1'b1) dexit_seen <= 1'b1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic sel, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_sel_pwr <= sel;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    ill_seen <= 1'b0;
    dexit_seen <= 1'b0;
  endtask

  task automatic stop_pulse();
    @(posedge mclk);
    stop_instr <= 1'b1;
    @(posedge mclk);
    stop_instr <= 1'b0;
    settle(3);
  endtask

  task automatic t_reset_values();
    settle(1);
    chk(gate_en, 32'h0000ffff);
    chk(32'(gen_mode), 32'(CGP_FEI));
    chk(osc_mult, 32'h200);
    chk(bus_div, 32'h1);
    chk(fll_select, 32'h1);
  endtask

  task automatic t_gating();
    bus(1'b1, 1'b0, CGP_ADDR_GATE, 32'h0000fef7); // module traffic is idle while gating
    settle(2);
    chk(gate_en, 32'h0000fef7);
    @(posedge mclk);
    periph_wr <= 16'hffff;
    @(posedge mclk);
    periph_wr <= 16'h0;
    #1;
    chk(periph_wr_ok, 32'h0000fef7);
    bus(1'b1, 1'b0, 4'h2, 32'h0);
    chk(rsp, 32'h2);
    do_reset();
    settle(1);
    chk(gate_en, 32'h0000ffff);
  endtask

  task automatic t_modes();
    logic [7:0] c1 [6] = '{8'h04, 8'h28, 8'h44, 8'h80, 8'h44, 8'h80};
    logic [7:0] c2 [6] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h48, 8'h48};
    cgp_gen_mode_e m [6] = '{CGP_FEI, CGP_FEE, CGP_FBI, CGP_FBE, CGP_BYPASSED_INTERNAL_LOW_POWER, CGP_BYPASSED_EXTERNAL_LOW_POWER};
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 1'b0, CGP_ADDR_GEN_CTRL2, {24'h0, c2[i]});
      bus(1'b1, 1'b0, CGP_ADDR_GEN_CTRL1, {24'h0, c1[i]}); // only the FEE entry sets a reference divider (5), the others leave it 0
      settle(2);
      chk(32'(gen_mode), 32'(m[i]));
      chk(fll_enable, {31'h0, ~c2[i][3]});
      chk(debug_clk_en, (i > 3) ? 32'h0 : 32'h1);
      chk(ext_ref_select, i % 2);
      chk(fll_select, (i < 2) ? 32'h1 : 32'h0);
      chk(ref_div, c1[i][5:3]);
    end
    bus(1'b1, 1'b0, CGP_ADDR_GEN_CTRL2, 32'hd0);
    settle(2);
    chk(high_gain_osc, 32'h1);
    chk(bus_div, 32'h3);
    bus(1'b1, 1'b0, CGP_ADDR_GEN_CTRL2, 32'h40);
    settle(2);
    chk(high_gain_osc, 32'h0);
    chk(bus_div, 32'h1);
  endtask

  task automatic t_stop_decode();
    // first write locks stop enable at 0
    bus(1'b1, 1'b0, CGP_ADDR_SYSOPT, 32'h0);
    stop_pulse();
    chk(ill_seen, 32'h1);
    chk(core_halt, 32'h0);
    bus(1'b1, 1'b0, CGP_ADDR_SYSOPT, 32'h1);
    stop_pulse();
    chk(core_halt, 32'h1);
    chk(sys_clk_run, 32'h1);
    @(posedge mclk);
    irq_any <= 1'b1;
    settle(3);
    chk(core_halt, 32'h0);
    @(posedge mclk);
    irq_any <= 1'b0;
    ill_seen <= 1'b0;
    bus(1'b1, 1'b0, CGP_ADDR_SYSOPT, 32'h2);
    stop_pulse();
    chk(ill_seen, 32'h1);
    chk(reg_standby, 32'h0);
  endtask

  task automatic wake_standby();
    int n;
    @(posedge mclk);
    irq_any <= 1'b1;
    settle(20);
    chk(sys_clk_run, 32'h0);
    @(posedge mclk);
    irq_any <= 1'b0;
    wake_src <= 8'h10;
    n = 0;
    while (sys_clk_run !== 1'b1 && n < 400) begin
      settle(1);
      n++;
    end
    @(posedge mclk);
    wake_src <= 8'h00;
    chk(n > 200 && n < 260, 32'h1);
  endtask

  task automatic t_standby();
    bus(1'b1, 1'b0, CGP_ADDR_GEN_CTRL1, 32'h80);
    bus(1'b1, 1'b0, CGP_ADDR_SYSOPT, 32'h2);
    stop_pulse();
    chk({sys_clk_run, reg_standby, reg_off}, 32'h2);
    wake_standby();
    chk(32'(gen_mode), 32'(CGP_FBE));
    bus(1'b1, 1'b1, CGP_ADDR_PWR, 32'h3);
    stop_pulse();
    chk({reg_standby, reg_off}, 32'h2);
    wake_standby();
  endtask

  task automatic t_deep();
    int n;
    bus(1'b1, 1'b0, CGP_ADDR_GATE, 32'h0);
    bus(1'b1, 1'b1, CGP_ADDR_PWR, 32'h1);
    stop_pulse();
    chk({sys_clk_run, reg_off, pin_latch}, 32'h3);
    @(posedge mclk);
    deep_wake <= 1'b1;
    settle(3);
    @(posedge mclk);
    deep_wake <= 1'b0;
    n = 0;
    while (sys_clk_run !== 1'b1 && n < 2000) begin
      settle(1);
      n++;
    end
    settle(2);
    chk(dexit_seen, 32'h1);
    chk(32'(gen_mode), 32'(CGP_FEI));
    chk({reg_off, pin_latch}, 32'h0);
    chk(gate_en, 32'h0000ffff);
    bus(1'b0, 1'b1, CGP_ADDR_PWR, 32'h0);
    chk(rd[CGP_PW_PARTIAL_POWER_DOWN_ACK], 32'h1);
  endtask

  initial begin
    do_reset();
    t_reset_values();
    t_gating();
    t_modes();
    t_stop_decode();
    do_reset();
    t_standby();
    t_deep();
    complete_run();
  end
endmodule // tb_top
